/* File: rtl/profile_gen.sv */
// Eight profile generators with a classic Wishbone register slave
`timescale 1ns/1ps
// Overview of operation
// - Eight independent profile generators
// - Four start modes and an off setting selectable per generator
// - Gate mode runs only while source above zero
// - Single shot runs to end once
// - Retrigger mode restarts on every rising edge
// - Calendar match starts the profile
// - Pause off ignores pause source
// - High pause holds while source above zero
// - Low pause holds while source not positive
// - Level pause stays paused on new trigger
// - Level pause outputs section one level or idle
// - Rising pause edge toggles pause
// - Falling pause edge toggles pause
// - Edge pause modes accept triggers normally
// - Idle value before and after run
// - Up to 100 sections with four fields
// - Loop off gives one pass
// - Counted loop runs loop count passes in total
// - Channel loop stops when count reaches channel
// - Infinite loop repeats endlessly
// - Repeats resume at re-entry section
// - Duration unit second, minute or hour
// - Ramp interpolates linearly over duration
// - Constant repeat section settles within 0.1 s
module profile_gen #(
  parameter int TICK_CYC = profile_gen_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                                   ref_clk,
  input  wire logic                                   nrst,
  // Wishbone slave
  input  wire logic                                   wb_cyc_i,
  input  wire logic                                   wb_stb_i,
  input  wire logic                                   wb_we_i,
  input  wire logic [profile_gen_pkg::ADR_W-1:0]      wb_adr_i,
  input  wire logic [3:0]                             wb_sel_i,
  input  wire logic [31:0]                            wb_dat_i,
  output logic      [31:0]                            wb_dat_o,
  output logic                                        wb_ack_o,
  // Channel sources and calendar matches
  input  wire profile_gen_pkg::chan_in_t [profile_gen_pkg::NGEN-1:0] chan_in,
  input  wire logic [profile_gen_pkg::NGEN-1:0]       cal_hit,
  // Generator outputs
  output wire profile_gen_pkg::level_t [profile_gen_pkg::NGEN-1:0] gen_out,
  output wire logic [profile_gen_pkg::NGEN-1:0]       gen_running
);
  import profile_gen_pkg::*;

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // ****************************************
  // Time base tick
  // ****************************************
  logic [31:0] tick_cnt_ff;
  logic        tick_ff;

  always_ff @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tick_cnt_ff <= 32'h0000_0000;
      tick_ff     <= 1'b0;
    end else if (tick_cnt_ff == 32'(TICK_CYC - 1)) begin
      tick_cnt_ff <= 32'h0000_0000;
      tick_ff     <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
      tick_ff     <= 1'b0;
    end
  end

  // ****************************************
  // Configuration storage
  // ****************************************
  ctrl_t    ctrl_ff   [NGEN];
  levels_t  levels_ff [NGEN];
  section_t sec_mem   [MEM_WORDS];

  logic [31:0] gen_status [NGEN];

  logic        req;
  logic [2:0]  a_gen;
  logic [9:0]  a_ofs;
  logic [9:0]  a_sec_ofs;
  logic [9:0]  a_mem;
  logic        a_is_sec;
  logic [31:0] rd_data;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign a_gen     = wb_adr_i[ADR_W-1:GEN_SHIFT];
  assign a_ofs     = wb_adr_i[GEN_SHIFT-1:0];
  assign a_sec_ofs = a_ofs - OFS_SEC_BASE;
  assign a_mem     = 10'(a_gen * NSEC) + {2'b00, a_sec_ofs[9:2]};
  assign a_is_sec  = (a_ofs >= OFS_SEC_BASE) && (a_ofs < OFS_SEC_END) && (a_ofs[1:0] == 2'b00);

  // Section memory writes
  always_ff @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        sec_mem[i] <= section_t'(SEC_RESET);
      end
    end else if (req && wb_we_i && a_is_sec) begin
      sec_mem[a_mem] <= section_t'(merge(sec_mem[a_mem], wb_dat_i, wb_sel_i));
    end
  end

  // Control and level register writes
  always_ff @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      for (int i = 0; i < NGEN; i++) begin
        ctrl_ff[i]   <= ctrl_t'(CTRL_RESET);
        levels_ff[i] <= levels_t'(LEVELS_RESET);
      end
    end else if (req && wb_we_i) begin
      if (a_ofs == OFS_CTRL) begin
        ctrl_ff[a_gen] <= ctrl_t'(merge(ctrl_ff[a_gen], wb_dat_i, wb_sel_i) & CTRL_MASK);
      end else if (a_ofs == OFS_LEVELS) begin
        levels_ff[a_gen] <= levels_t'(merge(levels_ff[a_gen], wb_dat_i, wb_sel_i));
      end
    end
  end


  // ****************************************
  // Bus read path
  // ****************************************
  // Read decode
  always_comb begin
    if (a_ofs == OFS_CTRL) begin
      rd_data = ctrl_ff[a_gen];
    end else if (a_ofs == OFS_LEVELS) begin
      rd_data = levels_ff[a_gen];
    end else if (a_ofs == OFS_STATUS) begin
      rd_data = gen_status[a_gen];
    end else if (a_ofs == OFS_OUTPUT) begin
      rd_data = {{16{gen_out[a_gen][15]}}, gen_out[a_gen]};
    end else if (a_is_sec) begin
      rd_data = sec_mem[a_mem];
    end else begin
      rd_data = RD_UNMAPPED;
    end
  end

  // Bus answer, one cycle after the request
  always_ff @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_data : 32'h0000_0000;
    end
  end

  // ****************************************
  // Generators
  // ****************************************
  for (genvar g = 0; g < NGEN; g++) begin : gen_blk
    gen_state_t  state_ff;
    logic        paused_ff;
    logic [6:0]  sec_ff;
    logic [24:0] elap_ff;
    logic [15:0] cyc_ff;
    level_t      start_lvl_ff;
    level_t      val_ff;
    logic        trig_prev_ff;
    logic        pause_prev_ff;
    logic        cal_prev_ff;

    ctrl_t             c;
    levels_t           lv;
    section_t          cur;
    section_t          first;
    logic [24:0]       total;
    logic              trig_pos;
    logic              pause_pos;
    logic              trig_rise;
    logic              start;
    logic              level_pause;
    logic              edge_mode;
    logic              toggle;
    logic              hold;
    logic              sec_done;
    logic              last;
    logic [15:0]       cyc_n;
    logic              again;
    logic [6:0]        reentry;
    logic signed [16:0] diff;
    logic signed [42:0] prod;
    logic signed [42:0] quot;
    level_t            ramp_val;

    assign c         = ctrl_ff[g];
    assign lv        = levels_ff[g];
    assign cur       = sec_mem[g*NSEC + int'(sec_ff)];
    assign first     = sec_mem[g*NSEC];
    assign trig_pos  = chan_in[g].trig > 16'sh0000;
    assign pause_pos = chan_in[g].pause > 16'sh0000;
    assign trig_rise = trig_pos && !trig_prev_ff;

    // Duration scaled by its unit
    always_comb begin
      case (cur.unit)
        UNIT_MIN:  total = 25'(cur.duration * MIN_PER_S);
        UNIT_HOUR: total = 25'(cur.duration * HOUR_PER_S);
        default:   total = {12'h000, cur.duration};
      endcase
    end


    // ****************************************
    // Start and pause decisions
    // ****************************************
    // Start decision per trigger mode
    always_comb begin
      case (c.trig_mode)
        TRIG_GATE:   start = trig_rise;
        TRIG_ONCE:   start = trig_rise && state_ff == ST_IDLE;
        TRIG_RETRIG: start = trig_rise;
        TRIG_TIME:   start = cal_hit[g] && !cal_prev_ff && state_ff == ST_IDLE;
        default:     start = 1'b0;
      endcase
      start = start && c.nsec != 7'h00;
    end

    assign level_pause = (c.pause_mode == PAUSE_HIGH && pause_pos)
                      || (c.pause_mode == PAUSE_LOW && !pause_pos);
    assign edge_mode   = c.pause_mode == PAUSE_RISE || c.pause_mode == PAUSE_FALL;
    assign toggle      = (c.pause_mode == PAUSE_RISE && pause_pos && !pause_prev_ff)
                      || (c.pause_mode == PAUSE_FALL && !pause_pos && pause_prev_ff);
    assign hold        = level_pause || (edge_mode && paused_ff);
    assign sec_done    = elap_ff + 25'h000_0001 >= total;
    assign last        = {1'b0, sec_ff} + 8'h01 >= {1'b0, c.nsec};
    assign cyc_n       = cyc_ff + 16'h0001;
    assign reentry     = c.reentry_segment < c.nsec ? c.reentry_segment : 7'h00;


    // ****************************************
    // Repeat and ramp
    // ****************************************
    // Repeat decision
    always_comb begin
      case (c.loop_mode)
        LOOP_COUNTED:  again = cyc_n < lv.loop_count;
        LOOP_CHANNEL:  again = $signed({1'b0, cyc_n}) < 17'(chan_in[g].loop_limit);
        LOOP_INFINITE: again = 1'b1;
        default:       again = 1'b0;
      endcase
    end

    // Linear ramp value
    assign diff     = 17'(cur.end_level) - 17'(start_lvl_ff);
    assign prod     = 43'(diff) * $signed({18'h00000, elap_ff});
    assign quot     = total == 25'h000_0000 ? 43'sh0 : prod / $signed({18'h00000, total});
    assign ramp_val = level_t'(start_lvl_ff + 16'(quot));


    // ****************************************
    // Edge history and pause state
    // ****************************************
    // Edge history
    always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
        trig_prev_ff  <= 1'b0;
        pause_prev_ff <= 1'b0;
        cal_prev_ff   <= 1'b0;
      end else begin
        trig_prev_ff  <= trig_pos;
        pause_prev_ff <= pause_pos;
        cal_prev_ff   <= cal_hit[g];
      end
    end

    // Edge toggled pause state
    always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
        paused_ff <= 1'b0;
      end else if (!edge_mode) begin
        paused_ff <= 1'b0;
      end else if (start) begin
        paused_ff <= 1'b0;
      end else if (toggle) begin
        paused_ff <= !paused_ff;
      end
    end


    // ****************************************
    // Section sequencing
    // ****************************************
    // Section sequencing
    always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
        state_ff     <= ST_IDLE;
        sec_ff       <= 7'h00;
        elap_ff      <= 25'h000_0000;
        cyc_ff       <= 16'h0000;
        start_lvl_ff <= 16'sh0000;
      end else if (start) begin
        state_ff     <= ST_RUN;
        sec_ff       <= 7'h00;
        elap_ff      <= 25'h000_0000;
        cyc_ff       <= 16'h0000;
        start_lvl_ff <= lv.idle_level;
      end else if (state_ff == ST_RUN && c.trig_mode == TRIG_GATE && !trig_pos) begin
        state_ff <= ST_IDLE;
      end else if (state_ff == ST_RUN && c.trig_mode == TRIG_OFF) begin
        state_ff <= ST_IDLE;
      end else if (state_ff == ST_RUN && !hold && tick_ff) begin
        if (!sec_done) begin
          elap_ff <= elap_ff + 25'h000_0001;
        end else if (!last) begin
          sec_ff       <= sec_ff + 7'h01;
          elap_ff      <= 25'h000_0000;
          start_lvl_ff <= cur.end_level;
        end else if (again) begin
          sec_ff       <= reentry;
          elap_ff      <= 25'h000_0000;
          cyc_ff       <= cyc_n;
          start_lvl_ff <= cur.end_level;
        end else begin
          state_ff <= ST_IDLE;
        end
      end
    end


    // ****************************************
    // Output level
    // ****************************************
    // Output level
    always_ff @(posedge ref_clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
        val_ff <= 16'sh0000;
      end else if (state_ff != ST_RUN) begin
        val_ff <= lv.idle_level;
      end else if (level_pause) begin
        val_ff <= first.shape == SHAPE_CONST ? first.end_level : lv.idle_level;
      end else if (cur.shape == SHAPE_CONST) begin
        val_ff <= cur.end_level;
      end else begin
        val_ff <= ramp_val;
      end
    end

    assign gen_out[g]     = val_ff;
    assign gen_running[g] = state_ff == ST_RUN;
    assign gen_status[g]  = {cyc_ff, 1'b0, sec_ff, 6'h00, hold, state_ff == ST_RUN};
  end

endmodule

/* File: rtl/profile_gen_pkg.sv */
// Shared constants, types and register map of the profile sequence generator
package profile_gen_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NGEN      = 8;
  localparam int NSEC      = 100;
  localparam int MEM_WORDS = NGEN * NSEC;
  localparam int ADR_W     = 13;

  // ****************************************
  // Time base
  // ****************************************
  localparam longint CLK_HZ       = 200_000_000;
  localparam longint TICK_PERIOD_S = 1;
  localparam int     TICK_CYCLES  = int'(CLK_HZ * TICK_PERIOD_S);
  localparam int     MIN_PER_S    = 60;
  localparam int     HOUR_PER_S   = 3600;

  // ****************************************
  // Register map (byte offsets inside one generator window)
  // ****************************************
  localparam int          GEN_SHIFT     = 10;
  localparam logic [9:0]  OFS_CTRL      = 10'h000;
  localparam logic [9:0]  OFS_LEVELS    = 10'h004;
  localparam logic [9:0]  OFS_STATUS    = 10'h008;
  localparam logic [9:0]  OFS_OUTPUT    = 10'h00C;
  localparam logic [9:0]  OFS_SEC_BASE  = 10'h200;
  localparam logic [9:0]  OFS_SEC_END   = 10'h390;
  localparam logic [31:0] CTRL_MASK     = 32'h7F7F_0377;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] LEVELS_RESET  = 32'h0000_0000;
  localparam logic [31:0] SEC_RESET     = 32'h0000_0000;
  localparam logic [31:0] RD_UNMAPPED   = 32'h0000_0000;

  // ****************************************
  // Types
  // ****************************************
  typedef logic signed [15:0] level_t;

  typedef enum logic [2:0] {TRIG_OFF, TRIG_GATE, TRIG_ONCE, TRIG_RETRIG, TRIG_TIME} trig_mode_t;
  typedef enum logic [2:0] {PAUSE_OFF, PAUSE_HIGH, PAUSE_LOW, PAUSE_RISE, PAUSE_FALL} pause_mode_t;
  typedef enum logic [1:0] {LOOP_OFF, LOOP_COUNTED, LOOP_CHANNEL, LOOP_INFINITE} loop_mode_t;
  typedef enum logic [1:0] {UNIT_SEC, UNIT_MIN, UNIT_HOUR} time_unit_t;
  typedef enum logic {SHAPE_CONST, SHAPE_RAMP} shape_t;
  typedef enum logic {ST_IDLE, ST_RUN} gen_state_t;

  typedef struct packed {
    logic        rsv1;
    logic [6:0]  reentry_segment;
    logic        rsv2;
    logic [6:0]  nsec;
    logic [5:0]  rsv3;
    loop_mode_t  loop_mode;
    logic        rsv4;
    pause_mode_t pause_mode;
    logic        rsv5;
    trig_mode_t  trig_mode;
  } ctrl_t;

  typedef struct packed {
    logic [15:0] loop_count;
    level_t      idle_level;
  } levels_t;

  typedef struct packed {
    shape_t      shape;
    time_unit_t  unit;
    logic [12:0] duration;
    level_t      end_level;
  } section_t;

  typedef struct packed {
    level_t trig;
    level_t pause;
    level_t loop_limit;
  } chan_in_t;

endpackage

/* File: testbench/profile_gen_chk.sv */
// Port checker for the profile generator, generator 0 and bus
`timescale 1ns/1ps
module profile_gen_chk (
  // Clock and reset
  input wire logic                                   ref_clk,
  input wire logic                                   nrst,
  // Wishbone
  input wire logic                                   wb_cyc_i,
  input wire logic                                   wb_stb_i,
  input wire logic                                   wb_we_i,
  input wire logic [profile_gen_pkg::ADR_W-1:0]      wb_adr_i,
  input wire logic [31:0]                            wb_dat_i,
  input wire logic [31:0]                            wb_dat_o,
  input wire logic                                   wb_ack_o,
  // Channels and outputs
  input wire profile_gen_pkg::chan_in_t [profile_gen_pkg::NGEN-1:0] chan_in,
  input wire logic [profile_gen_pkg::NGEN-1:0]       cal_hit,
  input wire profile_gen_pkg::level_t [profile_gen_pkg::NGEN-1:0] gen_out,
  input wire logic [profile_gen_pkg::NGEN-1:0]       gen_running
);
  import profile_gen_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  ctrl_t  ctrl_ff;
  level_t idle_ff;
  logic   wr0;
  level_t trg;
  assign wr0 = wb_ack_o && wb_we_i && (wb_adr_i[12:10] == 3'h0);
  assign trg = chan_in[0].trig;
  // Shadow of generator 0 settings
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= '0;
    end else if (wr0 && wb_adr_i[9:0] == OFS_CTRL) begin
      ctrl_ff <= wb_dat_i & CTRL_MASK;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      idle_ff <= '0;
    end else if (wr0 && wb_adr_i[9:0] == OFS_LEVELS) begin
      idle_ff <= wb_dat_i[15:0];
    end
  end
  sequence trig_rise;
    trg > 0 && $past(trg) <= 0;
  endsequence
  sequence armed(trig_mode_t m);
    ctrl_ff.trig_mode == m && ctrl_ff.nsec != 7'h0;
  endsequence
  AST_ACK_LAT:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  AST_ACK_PULSE:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_ACK_CAUSE:
    assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  AST_DAT_IDLE:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  AST_ONCE_GO:
    assert property (armed(TRIG_ONCE) ##0 trig_rise ##0 !gen_running[0] |=> gen_running[0])
      else $error("single shot not started");
  AST_RETRIG_GO:
    assert property (armed(TRIG_RETRIG) ##0 trig_rise |=> gen_running[0]) else $error("retrigger lost");
  AST_GATE_STOP:
    assert property (ctrl_ff.trig_mode == TRIG_GATE && trg <= 0 |=> !gen_running[0])
      else $error("gate run without source");
  AST_TIME_GO:
    assert property (armed(TRIG_TIME) ##0 $rose(cal_hit[0]) && !gen_running[0] |=> gen_running[0])
      else $error("calendar start lost");
  AST_OFF_HOLD:
    assert property (ctrl_ff.trig_mode == TRIG_OFF |=> !gen_running[0]) else $error("run while off");
  AST_IDLE_BACK:
    assert property ($fell(gen_running[0]) |=> gen_out[0] == idle_ff) else $error("no idle after run");
endmodule

bind profile_gen profile_gen_chk u_chk (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chan_in(chan_in), .cal_hit(cal_hit),
  .gen_out(gen_out), .gen_running(gen_running));

/* File: testbench/chan_src.sv */
// Channel source model: trigger, pause, loop limit and calendar hits
`timescale 1ns/1ps
module chan_src (
  // Clock
  input wire logic                                ref_clk,
  // Sources
  output profile_gen_pkg::chan_in_t [profile_gen_pkg::NGEN-1:0] chan_in,
  output logic [profile_gen_pkg::NGEN-1:0]        cal_hit
);
  import profile_gen_pkg::*;
  initial begin
    chan_in = '0;
    cal_hit = '0;
  end
  // Sources change just after a clock edge
  task automatic set_src(input int g, input level_t t, input level_t p, input level_t l);
    @(posedge ref_clk);
    chan_in[g] <= {t, p, l};
  endtask
  task automatic pulse_cal(input int g);
    @(posedge ref_clk);
    cal_hit[g] <= 1'b1;
    @(posedge ref_clk);
    cal_hit[g] <= 1'b0;
  endtask
endmodule

/* File: testbench/profile_gen_tb_top.sv */
// Self-checking bench of the profile generator
`timescale 1ns/1ps
module profile_gen_tb_top;
  import profile_gen_pkg::*;
  localparam int TC = 10;
  logic                 ref_clk, nrst, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [ADR_W-1:0]     wb_adr;
  logic [3:0]           wb_sel;
  logic [31:0]          wb_wdat, wb_rdat, q;
  chan_in_t [NGEN-1:0]  chan_in;
  logic [NGEN-1:0]      cal_hit, gen_running;
  level_t [NGEN-1:0]    gen_out;
  int                   fail_count, compares;

  profile_gen #(.TICK_CYC(TC)) u_dut (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .chan_in(chan_in), .cal_hit(cal_hit),
    .gen_out(gen_out), .gen_running(gen_running));
  chan_src u_src (.ref_clk(ref_clk), .chan_in(chan_in), .cal_hit(cal_hit));

  // ****
  // Helpers
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wb(input logic w, input int g, input logic [9:0] o, input logic [31:0] d);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= {g[2:0], o};
    wb_wdat <= d;
    do begin
      @(posedge ref_clk);
    end while (wb_ack !== 1'b1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge ref_clk);
  endtask
  function automatic logic [31:0] mk(trig_mode_t t, pause_mode_t p, loop_mode_t l, int re);
    ctrl_t c;
    c = '0;
    c.trig_mode = t;
    c.pause_mode = p;
    c.loop_mode = l;
    c.nsec = 7'h2;
    c.reentry_segment = 7'(re);
    return c;
  endfunction
  task automatic wait_end(input int lim, output int n);
    n = 0;
    while (gen_running[0] === 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_regs;
    wb(0, 0, OFS_CTRL, 0);
    chk(q, CTRL_RESET);
    wb(0, 0, OFS_LEVELS, 0);
    chk(q, LEVELS_RESET);
    wb(1, 0, OFS_CTRL, 32'hFFFF_FFFF);
    wb(0, 0, OFS_CTRL, 0);
    chk(q, CTRL_MASK);
    wb(1, 0, OFS_CTRL, 32'h0);
    wb(0, 0, 10'h010, 0);
    chk(q, RD_UNMAPPED);
    wb(1, 0, OFS_SEC_END - 10'h4, 32'hA5A5_1234);
    wb(0, 0, OFS_SEC_END - 10'h4, 0);
    chk(q, 32'hA5A5_1234);
    wb(1, 3, OFS_LEVELS, 32'h0000_0033);
    cyc(3);
    chk(gen_out[3], 16'h0033);
    chk(gen_out[0], 16'h0000);
    $display("t_regs done");
  endtask
  task automatic run(input logic [31:0] c, input logic [31:0] lv, input level_t lim, input int t);
    int n;
    wb(1, 0, OFS_CTRL, c);
    wb(1, 0, OFS_LEVELS, lv);
    chk(gen_out[0], lv[15:0]);
    u_src.set_src(0, 16'sh1, 16'sh0, lim);
    u_src.set_src(0, 16'sh0, 16'sh0, lim);
    cyc(3);
    chk(gen_out[0], 16'h0100);
    wait_end(2000, n);
    chk(n >= (t - 1) * TC - 3 && n <= t * TC, 1'b1);
    cyc(1);
    chk(gen_out[0], lv[15:0]);
    $display("run done");
  endtask
  task automatic t_retrig_gate;
    wb(1, 0, OFS_CTRL, mk(TRIG_RETRIG, PAUSE_OFF, LOOP_OFF, 0));
    u_src.set_src(0, 16'sh1, 16'sh0, 16'sh0);
    cyc(30);
    chk(gen_out[0], 16'h0200);
    u_src.set_src(0, 16'sh0, 16'sh0, 16'sh0);
    u_src.set_src(0, 16'sh1, 16'sh0, 16'sh0);
    cyc(4);
    chk(gen_out[0], 16'h0100);
    wb(1, 0, OFS_CTRL, mk(TRIG_GATE, PAUSE_OFF, LOOP_OFF, 0));
    u_src.set_src(0, 16'sh0, 16'sh0, 16'sh0);
    u_src.set_src(0, 16'sh1, 16'sh0, 16'sh0);
    cyc(5);
    chk(gen_running[0], 1'b1);
    u_src.set_src(0, 16'sh0, 16'sh0, 16'sh0);
    cyc(3);
    chk(gen_running[0], 1'b0);
    $display("t_retrig_gate done");
  endtask
  task automatic t_pause(input pause_mode_t pm);
    int n;
    wb(1, 0, OFS_CTRL, mk(TRIG_ONCE, pm, LOOP_OFF, 0));
    u_src.set_src(0, 16'sh1, 16'sh0, 16'sh0);
    cyc(3);
    u_src.set_src(0, 16'sh0, 16'sh1, 16'sh0);
    if (pm >= PAUSE_RISE) u_src.set_src(0, 16'sh0, 16'sh0, 16'sh0);
    cyc(80);
    chk(gen_running[0], pm != PAUSE_OFF);
    if (pm == PAUSE_HIGH) chk(gen_out[0], 16'h0100);
    if (pm >= PAUSE_RISE) u_src.set_src(0, 16'sh0, 16'sh1, 16'sh0);
    u_src.set_src(0, 16'sh0, 16'sh0, 16'sh0);
    wait_end(60, n);
    chk(gen_running[0], 1'b0);
    $display("t_pause done");
  endtask
  task automatic t_inf_time;
    wb(1, 0, OFS_CTRL, mk(TRIG_ONCE, PAUSE_OFF, LOOP_INFINITE, 1));
    u_src.set_src(0, 16'sh1, 16'sh0, 16'sh0);
    u_src.set_src(0, 16'sh0, 16'sh0, 16'sh0);
    cyc(300);
    chk(gen_running[0], 1'b1);
    wb(1, 0, OFS_CTRL, mk(TRIG_OFF, PAUSE_OFF, LOOP_OFF, 0));
    cyc(3);
    chk(gen_running[0], 1'b0);
    wb(1, 0, OFS_CTRL, mk(TRIG_TIME, PAUSE_OFF, LOOP_OFF, 0));
    u_src.pulse_cal(0);
    cyc(2);
    chk(gen_running[0], 1'b1);
    $display("t_inf_time done");
  endtask

  task automatic report_and_stop;
    $display("Compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    report_and_stop();
  end
  initial begin
    {nrst, wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} = '0;
    wb_sel = 4'hF;
    fail_count = 0;
    compares = 0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    cyc(4);
    t_regs();
    wb(1, 0, OFS_SEC_BASE, 32'h0002_0100);
    wb(1, 0, OFS_SEC_BASE + 10'h4, 32'h0003_0200);
    run(mk(TRIG_ONCE, PAUSE_OFF, LOOP_OFF, 1), 32'h0000_0011, 16'sh0, 5);
    run(mk(TRIG_ONCE, PAUSE_OFF, LOOP_COUNTED, 1), 32'h0002_0011, 16'sh0, 8);
    run(mk(TRIG_ONCE, PAUSE_OFF, LOOP_CHANNEL, 1), 32'h0000_0012, 16'sh3, 11);
    t_retrig_gate();
    t_pause(PAUSE_OFF);
    t_pause(PAUSE_HIGH);
    t_pause(PAUSE_RISE);
    t_pause(PAUSE_FALL);
    t_inf_time();
    report_and_stop();
  end
endmodule
